// >>> rtl/stc_pkg.sv
package stc_pkg;

   // ************************************************************
   // Clock and chopper oscillator timing
   // ************************************************************
   localparam int unsigned STC_CLK_HZ       = 10_000_000;
   localparam int unsigned STC_OSC_HZ       = 25_000;
   localparam int unsigned STC_OSC_DIV_CALC = STC_CLK_HZ / STC_OSC_HZ;
   localparam logic [15:0] STC_OSC_DIV_RST  = STC_OSC_DIV_CALC[15:0];

   // ************************************************************
   // Register map (byte addresses, one 32-bit word each)
   // ************************************************************
   localparam logic [7:0] STC_CTRL_OFF    = 8'h00;
   localparam logic [7:0] STC_OSC_DIV_OFF = 8'h04;
   localparam logic [7:0] STC_STATUS_OFF  = 8'h08;

   // Control register fields and reset value
   localparam int unsigned STC_CTRL_OSC_EN_BIT = 0;
   localparam logic [7:0]  STC_CTRL_RST        = 8'h01;

   // Status register fields
   localparam int unsigned STC_ST_STATE_LSB  = 0;
   localparam int unsigned STC_ST_HOME_BIT   = 3;
   localparam int unsigned STC_ST_LATCH_AB   = 4;
   localparam int unsigned STC_ST_LATCH_CD   = 5;
   localparam int unsigned STC_ST_HALF_BIT   = 6;
   localparam int unsigned STC_ST_DIR_BIT    = 7;

   // ************************************************************
   // Translator constants
   // ************************************************************
   localparam logic [2:0] STC_HOME_STATE  = 3'h0;
   localparam logic [3:0] STC_HOME_PHASE  = 4'h5;
   localparam logic [2:0] STC_STEP_HALF   = 3'h1;
   localparam logic [2:0] STC_STEP_FULL   = 3'h2;

   // Phase lines {A,B,C,D} for state index 0..7 (states 1..8)
   function automatic logic [3:0] stc_phase(input logic [2:0] idx);
      logic [3:0] p;
      p = 4'h5;
      unique case (idx)
         3'd0: p = 4'h5;
         3'd1: p = 4'h1;
         3'd2: p = 4'h9;
         3'd3: p = 4'h8;
         3'd4: p = 4'hA;
         3'd5: p = 4'h2;
         3'd6: p = 4'h6;
         3'd7: p = 4'h4;
      endcase
      return p;
   endfunction : stc_phase

endpackage : stc_pkg

// >>> rtl/stc_osc.sv
`timescale 1ns/1ps
// Chopper oscillator: runs its own divider and drives the sync pin, or
// follows rising edges arriving on the sync pin from another device.
module stc_osc
   import stc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        osc_en_in,
   input  wire logic [15:0] div_in,
   input  wire logic        sync_in,
   output logic             pulse_out,
   output logic             sync_out,
   output logic             sync_oe_n_out
);

   logic [15:0] cnt_reg;
   logic        sync_prev_reg;

   // ************************************************************
   // Divider and pulse generation
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_reg       <= 16'h0000;
         sync_prev_reg <= 1'b0;
         pulse_out     <= 1'b0;
         sync_out      <= 1'b0;
         sync_oe_n_out <= 1'b1;
      end else begin
         sync_prev_reg <= sync_in;
         sync_oe_n_out <= ~osc_en_in;          // Low while driving the pin
         if (osc_en_in) begin
            // A divider of 0 or 1 gives a pulse on every cycle
            if ((div_in <= 16'h0001) || (cnt_reg >= div_in - 16'h0001)) begin
               cnt_reg   <= 16'h0000;
               pulse_out <= 1'b1;
               sync_out  <= 1'b1;
            end else begin
               cnt_reg   <= cnt_reg + 16'h0001;
               pulse_out <= 1'b0;
               sync_out  <= 1'b0;
            end
         end else begin
            cnt_reg   <= 16'h0000;
            sync_out  <= 1'b0;
            pulse_out <= sync_in & ~sync_prev_reg; // External chopper clock
         end
      end
   end

endmodule : stc_osc

// >>> rtl/stc_wb.sv
`timescale 1ns/1ps
// Classic Wishbone slave holding the control and divider registers.
module stc_wb
   import stc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        cyc_in,
   input  wire logic        stb_in,
   input  wire logic        we_in,
   input  wire logic [7:0]  adr_in,
   input  wire logic [3:0]  sel_in,
   input  wire logic [31:0] dat_in,
   input  wire logic [7:0]  status_in,
   output logic [31:0]      dat_out,
   output logic             ack_out,
   output logic [7:0]       ctrl_out,
   output logic [15:0]      div_out
);

   logic wr_commit;

   // Write lands at the edge where the master sees ack
   assign wr_commit = cyc_in & stb_in & we_in & ack_out;

   // ************************************************************
   // Acknowledge and read data
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         dat_out <= 32'h0000_0000;
      end else begin
         ack_out <= cyc_in & stb_in & ~ack_out;
         unique case (adr_in)
            STC_CTRL_OFF:    dat_out <= {24'h00_0000, ctrl_out};
            STC_OSC_DIV_OFF: dat_out <= {16'h0000, div_out};
            STC_STATUS_OFF:  dat_out <= {24'h00_0000, status_in};
            default:         dat_out <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Register writes with byte lanes
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_out <= STC_CTRL_RST;
         div_out  <= STC_OSC_DIV_RST;
      end else if (wr_commit) begin
         if (adr_in == STC_CTRL_OFF && sel_in[0]) begin
            ctrl_out <= dat_in[7:0];
         end
         if (adr_in == STC_OSC_DIV_OFF) begin
            if (sel_in[0]) begin
               div_out[7:0] <= dat_in[7:0];
            end
            if (sel_in[1]) begin
               div_out[15:8] <= dat_in[15:8];
            end
         end
      end
   end

endmodule : stc_wb

// >>> rtl/stc_top.sv
`timescale 1ns/1ps

// Functional notes
// - Home output released whenever translator sits in state 1, phases 0101.
// - Enable low forces both inhibits and all four phase lines low.
// - Chop target low chops inhibit lines; high chops phase lines.
// - Direction input is synchronised internally, may change any time.
// - Translator advances one state (half step) or two (full step) on step clock rising edge.
// - Step size high selects half step, low selects full step.
// - Full step at even state is one-phase-on, at odd state two-phase-on.
// - Reset pin low returns translator to home state 1.
// - Inhibits go low on a de-energised winding in half and wave modes.
// - Phase chopping activates the inactive line of each energised pair.
// - Each oscillator pulse sets both chopper latches.
// - Sense trip clears its winding latch, drive off until next pulse.
// - External chopper clock accepted on sync pin; one device drives it.
// - Anticlockwise walks the same sequence in reverse.
// - Normal drive keeps both inhibits high, except when chop target low chops them.
// - Three sequences: normal, wave and half step.
module stc_top
   import stc_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RESET_N_IN,
   // Wishbone slave
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [7:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic [31:0]      WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   // Host control pins
   input  wire logic        STEP_CLK_N_IN,
   input  wire logic        STEP_RESET_N_IN,
   input  wire logic        DIRECTION_SELECT_IN,
   input  wire logic        HALF_STEP_SEL_IN,
   input  wire logic        CHIP_ENABLE_IN,
   input  wire logic        CHOP_PHASE_SEL_IN,
   // Current sense comparator results (high = peak reached)
   input  wire logic        SENSE_AB_IN,
   input  wire logic        SENSE_CD_IN,
   // Chopper sync pin
   input  wire logic        CHOP_SYNC_IN,
   output logic             CHOP_SYNC_OUT,
   output logic             CHOP_SYNC_OE_N_OUT,
   // Power stage drive
   output logic [3:0]       PHASE_LINES_OUT,
   output logic             INHIBIT_AB_N_OUT,
   output logic             INHIBIT_CD_N_OUT,
   // Open-collector home output
   output logic             HOME_OUT,
   output logic             HOME_OE_N_OUT
);

   logic [2:0]  state_reg;
   logic [2:0]  state_next;
   logic        step_prev_reg;
   logic        dir_meta_reg;
   logic        dir_sync_reg;
   logic        chop_latch_ab;
   logic        chop_latch_cd;
   logic        step_rise;
   logic        osc_pulse;
   logic [7:0]  ctrl;
   logic [15:0] osc_div;
   logic [7:0]  status;
   logic [3:0]  phase_lines;
   logic [3:0]  phase_drive;
   logic        inhibit_ab_n;
   logic        inhibit_cd_n;
   logic        is_home;

   // ************************************************************
   // Register bus and chopper oscillator
   // ************************************************************
   stc_wb u_wb (
      .clk_in    (SYS_CLK_IN),
      .rst_n_in  (RESET_N_IN),
      .cyc_in    (WB_CYC_IN),
      .stb_in    (WB_STB_IN),
      .we_in     (WB_WE_IN),
      .adr_in    (WB_ADR_IN),
      .sel_in    (WB_SEL_IN),
      .dat_in    (WB_DAT_IN),
      .status_in (status),
      .dat_out   (WB_DAT_OUT),
      .ack_out   (WB_ACK_OUT),
      .ctrl_out  (ctrl),
      .div_out   (osc_div)
   );

   // Own oscillator or external clock on the sync pin
   stc_osc u_osc (
      .clk_in        (SYS_CLK_IN),
      .rst_n_in      (RESET_N_IN),
      .osc_en_in     (ctrl[STC_CTRL_OSC_EN_BIT]),
      .div_in        (osc_div),
      .sync_in       (CHOP_SYNC_IN),
      .pulse_out     (osc_pulse),
      .sync_out      (CHOP_SYNC_OUT),
      .sync_oe_n_out (CHOP_SYNC_OE_N_OUT)
   );

   // Status word seen by software
   assign status = {dir_sync_reg, HALF_STEP_SEL_IN, chop_latch_cd, chop_latch_ab,
                    is_home, state_reg};

   // ************************************************************
   // Direction synchroniser and step edge detect
   // ************************************************************
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         dir_meta_reg  <= 1'b0;
         dir_sync_reg  <= 1'b0;
         step_prev_reg <= 1'b1;
      end else begin
         dir_meta_reg  <= DIRECTION_SELECT_IN;
         dir_sync_reg  <= dir_meta_reg;
         step_prev_reg <= STEP_CLK_N_IN;
      end
   end

   // Low-to-high transition ends the step pulse
   assign step_rise = STEP_CLK_N_IN & ~step_prev_reg;

   // ************************************************************
   // Translator counter
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      if (step_rise) begin
         if (HALF_STEP_SEL_IN) begin
            // Half step walks every state
            state_next = dir_sync_reg ? state_reg + STC_STEP_HALF
                                      : state_reg - STC_STEP_HALF;
         end else begin
            // Full step keeps parity: odd states two-on, even one-on
            state_next = dir_sync_reg ? state_reg + STC_STEP_FULL
                                      : state_reg - STC_STEP_FULL;
         end
      end
   end

   // Reset pin overrides any step
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         state_reg <= STC_HOME_STATE;
      end else if (!STEP_RESET_N_IN) begin
         state_reg <= STC_HOME_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Chopper latches
   // ************************************************************
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         chop_latch_ab <= 1'b0;
         chop_latch_cd <= 1'b0;
      end else begin
         if (osc_pulse) begin
            chop_latch_ab <= 1'b1;
         end else if (SENSE_AB_IN) begin
            chop_latch_ab <= 1'b0;
         end
         if (osc_pulse) begin
            chop_latch_cd <= 1'b1;
         end else if (SENSE_CD_IN) begin
            chop_latch_cd <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Output decode
   // ************************************************************
   assign phase_lines = stc_phase(state_reg);
   assign is_home     = (phase_lines == STC_HOME_PHASE);

   always_comb begin
      // Winding off means its inhibit goes low for fast decay
      inhibit_ab_n = phase_lines[3] | phase_lines[2];
      inhibit_cd_n = phase_lines[1] | phase_lines[0];
      phase_drive  = phase_lines;
      if (CHOP_PHASE_SEL_IN) begin
         // Turn on the idle line of an energised pair
         if (!chop_latch_ab && inhibit_ab_n) begin
            phase_drive[3:2] = 2'b11;
         end
         if (!chop_latch_cd && inhibit_cd_n) begin
            phase_drive[1:0] = 2'b11;
         end
      end else begin
         inhibit_ab_n = inhibit_ab_n & chop_latch_ab;
         inhibit_cd_n = inhibit_cd_n & chop_latch_cd;
      end
   end

   // Registered pin drivers
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESET_N_IN) begin
         PHASE_LINES_OUT  <= 4'h0;
         INHIBIT_AB_N_OUT <= 1'b0;
         INHIBIT_CD_N_OUT <= 1'b0;
         HOME_OUT         <= 1'b0;
         HOME_OE_N_OUT    <= 1'b1;
      end else begin
         if (CHIP_ENABLE_IN) begin
            PHASE_LINES_OUT  <= phase_drive;
            INHIBIT_AB_N_OUT <= inhibit_ab_n;
            INHIBIT_CD_N_OUT <= inhibit_cd_n;
         end else begin
            PHASE_LINES_OUT  <= 4'h0;
            INHIBIT_AB_N_OUT <= 1'b0;
            INHIBIT_CD_N_OUT <= 1'b0;
         end
         HOME_OUT      <= 1'b0;
         HOME_OE_N_OUT <= is_home;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   home_release_a: assert property (
      (state_reg == STC_HOME_STATE) |=> HOME_OE_N_OUT)
      else $error("home output not released in state 1");

   enable_off_a: assert property (
      !CHIP_ENABLE_IN |=> (PHASE_LINES_OUT == 4'h0) && !INHIBIT_AB_N_OUT
                          && !INHIBIT_CD_N_OUT)
      else $error("outputs not forced low while disabled");

   inhibit_chop_a: assert property (
      CHIP_ENABLE_IN && !CHOP_PHASE_SEL_IN && !chop_latch_ab |=> !INHIBIT_AB_N_OUT)
      else $error("inhibit not chopped");

   half_step_a: assert property (
      step_rise && STEP_RESET_N_IN && HALF_STEP_SEL_IN && dir_sync_reg
      |=> state_reg == 3'($past(state_reg) + 3'h1))
      else $error("half step did not advance by one");

   full_back_a: assert property (
      step_rise && STEP_RESET_N_IN && !HALF_STEP_SEL_IN && !dir_sync_reg
      |=> state_reg == 3'($past(state_reg) - 3'h2))
      else $error("reverse full step wrong");

   idle_hold_a: assert property (
      !step_rise && STEP_RESET_N_IN |=> $stable(state_reg))
      else $error("translator moved without a step");

   pin_reset_a: assert property (
      !STEP_RESET_N_IN |=> state_reg == STC_HOME_STATE ##1 HOME_OE_N_OUT)
      else $error("reset pin did not return home");

   osc_set_a: assert property (
      osc_pulse |=> chop_latch_ab && chop_latch_cd)
      else $error("oscillator pulse did not set latches");

   sense_clear_a: assert property (
      SENSE_AB_IN && !osc_pulse |=> !chop_latch_ab)
      else $error("sense trip did not clear latch");

   normal_inh_a: assert property (
      CHIP_ENABLE_IN && CHOP_PHASE_SEL_IN && !state_reg[0]
      |=> INHIBIT_AB_N_OUT && INHIBIT_CD_N_OUT)
      else $error("inhibit dropped in two-phase state");

   phase_chop_a: assert property (
      CHIP_ENABLE_IN && CHOP_PHASE_SEL_IN && !chop_latch_ab
      && (phase_lines[3] | phase_lines[2]) |=> PHASE_LINES_OUT[3:2] == 2'b11)
      else $error("idle phase line not activated");

   dir_sync_a: assert property (
      $changed(DIRECTION_SELECT_IN) |-> ##2 dir_sync_reg == $past(DIRECTION_SELECT_IN, 2))
      else $error("direction synchroniser latency wrong");

   home_pull_a: assert property (
      (state_reg != STC_HOME_STATE) |=> !HOME_OE_N_OUT)
      else $error("home output released away from state 1");

   sense_cd_clear_a: assert property (
      SENSE_CD_IN && !osc_pulse |=> !chop_latch_cd)
      else $error("sense trip did not clear cd latch");

   phase_chop_cd_a: assert property (
      CHIP_ENABLE_IN && CHOP_PHASE_SEL_IN && !chop_latch_cd
      && (phase_lines[1] | phase_lines[0]) |=> PHASE_LINES_OUT[1:0] == 2'b11)
      else $error("idle cd phase line not activated");

   // Main scenarios: wrap, chopping, full steps both ways
   wrap_cov: cover property (step_rise && state_reg == 3'h7 && dir_sync_reg);
   chop_cov: cover property (osc_pulse ##[1:500] SENSE_AB_IN);
   full_cov: cover property (step_rise && !HALF_STEP_SEL_IN && state_reg[0]);
   back_full_cov: cover property (step_rise && !HALF_STEP_SEL_IN && !dir_sync_reg);
   cd_chop_cov: cover property (CHIP_ENABLE_IN && CHOP_PHASE_SEL_IN && !chop_latch_cd);

endmodule : stc_top

// >>> tb/stc_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host controller model: step, mode and sense stimulus
// ************************************************************
module stc_host_model (
   input  wire logic clk_in,
   output logic      step_clk_n_out,
   output logic      step_reset_n_out,
   output logic      dir_out,
   output logic      half_out,
   output logic      enable_out,
   output logic      chop_sel_out,
   output logic      sense_ab_out,
   output logic      sense_cd_out,
   output logic      ext_sync_out
);
   // Idle levels at time zero
   initial begin
      step_clk_n_out   = 1'b1;
      step_reset_n_out = 1'b1;
      dir_out          = 1'b1;
      half_out         = 1'b1;
      enable_out       = 1'b1;
      chop_sel_out     = 1'b0;
      sense_ab_out     = 1'b0;
      sense_cd_out     = 1'b0;
      ext_sync_out     = 1'b0;
   end

   // Active-low step pulse; direction changes as the pulse starts
   task automatic step(input logic dir, input int low_cyc);
      @(posedge clk_in);
      step_clk_n_out <= 1'b0;
      dir_out        <= dir;
      repeat (low_cyc) @(posedge clk_in);
      step_clk_n_out <= 1'b1;
      @(posedge clk_in);
   endtask : step

   // Mode pins, held a cycle before any step
   task automatic pins(input logic en, input logic half, input logic chop);
      @(posedge clk_in);
      enable_out   <= en;
      half_out     <= half;
      chop_sel_out <= chop;
      @(posedge clk_in);
   endtask : pins

   // One-cycle comparator trip
   task automatic trip(input logic ab, input logic cd);
      @(posedge clk_in);
      sense_ab_out <= ab;
      sense_cd_out <= cd;
      @(posedge clk_in);
      sense_ab_out <= 1'b0;
      sense_cd_out <= 1'b0;
   endtask : trip

   // External chopper clock pulse on the shared sync line
   task automatic sync_pulse();
      @(posedge clk_in);
      ext_sync_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_sync_out <= 1'b0;
   endtask : sync_pulse

   // Translator reset with a step attempted while it is held
   task automatic reset_pin();
      @(posedge clk_in);
      step_reset_n_out <= 1'b0;
      step(dir_out, 1);
      step_reset_n_out <= 1'b1;
   endtask : reset_pin
endmodule : stc_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
// ************************************************************
// Testbench for the stepper translator and chopper
// ************************************************************
module tb;
   import stc_pkg::*;
   logic        clk, rst_n, cyc, stb, we, ack, home, home_oe_n;
   logic        sync_out, sync_oe_n, sync_w, inh_ab_n, inh_cd_n;
   logic        step_n, step_rst_n, dir, half, en, chop, s_ab, s_cd, ext_sync;
   logic [7:0]  adr;
   logic [3:0]  sel, phase;
   logic [31:0] wdat, rdat;
   logic [2:0]  st;
   logic [3:0]  tbl [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4};
   int          mismatches, n_tests;

   // Shared sync line: device drives it while its enable is low
   assign sync_w = sync_oe_n ? ext_sync : sync_out;

   stc_top uut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .STEP_CLK_N_IN(step_n),
      .STEP_RESET_N_IN(step_rst_n), .DIRECTION_SELECT_IN(dir), .HALF_STEP_SEL_IN(half),
      .CHIP_ENABLE_IN(en), .CHOP_PHASE_SEL_IN(chop), .SENSE_AB_IN(s_ab),
      .SENSE_CD_IN(s_cd), .CHOP_SYNC_IN(sync_w), .CHOP_SYNC_OUT(sync_out),
      .CHOP_SYNC_OE_N_OUT(sync_oe_n), .PHASE_LINES_OUT(phase),
      .INHIBIT_AB_N_OUT(inh_ab_n), .INHIBIT_CD_N_OUT(inh_cd_n), .HOME_OUT(home),
      .HOME_OE_N_OUT(home_oe_n));

   stc_host_model host (.clk_in(clk), .step_clk_n_out(step_n),
      .step_reset_n_out(step_rst_n), .dir_out(dir), .half_out(half), .enable_out(en),
      .chop_sel_out(chop), .sense_ab_out(s_ab), .sense_cd_out(s_cd),
      .ext_sync_out(ext_sync));

   // Clock of 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Compare drive outputs against the expected translator state
   task automatic chk_pins();
      logic [3:0] p;
      p = tbl[st];
      chk(32'(phase), 32'(p));
      chk(32'(inh_ab_n), 32'(|p[3:2]));
      chk(32'(inh_cd_n), 32'(|p[1:0]));
      chk(32'(home_oe_n), 32'(st == 3'h0));
      chk(32'(home), 32'h0);
   endtask : chk_pins

   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   // Step and let the outputs settle
   task automatic stp(input logic d, input int lc);
      host.step(d, lc);
      repeat (3) @(posedge clk);
   endtask : stp

   // Register reset values, unmapped place and read-back
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, STC_CTRL_OFF, 32'h0, q);
      chk(q, 32'h1);
      wb(1'b0, STC_OSC_DIV_OFF, 32'h0, q);
      chk(q, 32'(STC_OSC_DIV_RST));
      wb(1'b0, STC_STATUS_OFF, 32'h0, q);
      chk(q & 32'hCF, 32'hC8);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, STC_OSC_DIV_OFF, 32'hABCD_0123, q);
      wb(1'b0, STC_OSC_DIV_OFF, 32'h0, q);
      chk(q, 32'h0123);
      wb(1'b1, STC_OSC_DIV_OFF, 32'(STC_OSC_DIV_RST), q);
   endtask : t_regs

   // Half step round both ways, direction flipped inside the pulse
   task automatic t_half();
      // Inhibits stay low until the own oscillator has set both latches
      while (sync_out !== 1'b1) begin
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
      chk_pins();
      for (int i = 0; i < 8; i++) begin
         stp(1'b1, 1);
         st = st + STC_STEP_HALF;
         chk_pins();
      end
      for (int i = 0; i < 8; i++) begin
         stp(1'b0, 3);
         st = st - STC_STEP_HALF;
         chk_pins();
      end
   endtask : t_half

   // Normal drive from an odd state, wave drive from an even one
   task automatic t_full();
      host.pins(1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         stp(1'b1, 3);
         st = st + STC_STEP_FULL;
         chk_pins();
      end
      host.pins(1'b1, 1'b1, 1'b0);
      stp(1'b1, 1);
      st = st + STC_STEP_HALF;
      host.pins(1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         stp(1'b1, 2);
         st = st + STC_STEP_FULL;
         chk_pins();
      end
      stp(1'b0, 3);
      st = st - STC_STEP_FULL;
      chk_pins();
      host.pins(1'b1, 1'b1, 1'b0);
      host.reset_pin();
      repeat (3) @(posedge clk);
      st = STC_HOME_STATE;
      chk_pins();
   endtask : t_full

   // Enable low forces the drive lines low
   task automatic t_enable();
      host.pins(1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      chk(32'({phase, inh_ab_n, inh_cd_n}), 32'h0);
      host.pins(1'b1, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      chk_pins();
   endtask : t_enable

   // Chopping on inhibits then phase lines from the external clock, then own clock drives sync
   task automatic t_chop();
      logic [31:0] q;
      int          n;
      wb(1'b1, STC_CTRL_OFF, 32'h0, q);
      repeat (3) @(posedge clk);
      chk(32'(sync_oe_n), 32'h1);
      host.sync_pulse();
      host.trip(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      chk(32'({phase, inh_ab_n, inh_cd_n}), 32'h15);
      wb(1'b0, STC_STATUS_OFF, 32'h0, q);
      chk(q & 32'h30, 32'h20);
      host.sync_pulse();
      repeat (4) @(posedge clk);
      chk_pins();
      host.pins(1'b1, 1'b1, 1'b1);
      host.trip(1'b1, 1'b1);
      repeat (4) @(posedge clk);
      chk(32'({phase, inh_ab_n, inh_cd_n}), 32'h3F);
      host.sync_pulse();
      repeat (4) @(posedge clk);
      chk_pins();
      wb(1'b1, STC_CTRL_OFF, 32'h1, q);
      n = 0;
      while (sync_out !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk(32'({sync_out, sync_oe_n}), 32'h2);
   endtask : t_chop

   // Verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // Watchdog: the tests need about a thousand cycles, allow ten thousand
   initial begin
      #1_000_000;
      mismatches++;
      end_sim();
   end

   // Main sequence
   initial begin
      mismatches = 0;
      n_tests    = 0;
      st         = STC_HOME_STATE;
      rst_n      = 1'b0;
      {cyc, stb, we} = 3'h0;
      adr        = 8'h00;
      sel        = 4'hF;
      wdat       = 32'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_half();
      t_full();
      t_enable();
      t_chop();
      end_sim();
   end
endmodule : tb
